//--- pma_pkg.sv
// package: constants and carrier types for the packet memory arbiter
package pma_pkg;

  localparam int CHANNELS = 16;
  localparam int CH_W = 4;
  localparam int PTR_W = 8;
  localparam int ADDR_W = 9;
  localparam int MEM_BYTES = 512;
  localparam int CNT_W = 10;
  // channel number bit that selects page 1 of the store
  localparam int PAGE_BIT = 3;

  // register select within a channel
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_RPTR = 2'h1;
  localparam logic [1:0] SEL_WPTR = 2'h2;

  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_STEP = 10'h001;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [CH_W-1:0] ch;
    logic [1:0] sel;
    logic [7:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic in_take;
    logic out_put;
    logic restart;
    logic [CH_W-1:0] ch;
    logic [7:0] wdata;
    logic [CNT_W-1:0] limit;
  } engine_req_t;

  typedef enum logic [1:0] {
    FETCH_NONE,
    FETCH_CORE,
    FETCH_ENGINE
  } fetch_t;

endpackage : pma_pkg

//--- packet_memory_arbiter.sv
// module: packet memory with channel pointers shared by core and engine
//
// What this block does
// - each channel: write pointer, read pointer, data port
// - data write stores byte, bumps write pointer
// - write pointer read gives next write address
// - data read returns prefetch, bumps, fetches next
// - read pointer write preloads data holding register
// - engine has private port beside core
// - in: byte counter offsets read base, prefetch
// - out: store at write base plus count
// - out resend restarts byte counter at zero
// - bytes past limit dropped, still counted
// - sixteen channels over two pages
// - dedicated 512-byte store, channels only
`timescale 1ns/1ps
module packet_memory_arbiter
  import pma_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire core_req_t core_i,
  output logic [7:0] core_rdata_o,
  input wire engine_req_t engine_i,
  output logic [7:0] engine_rdata_o,
  output logic [CNT_W-1:0] engine_count_o
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0] mem [MEM_BYTES];
  logic [PTR_W-1:0] wptr [CHANNELS];
  logic [PTR_W-1:0] rptr [CHANNELS];
  logic [7:0] hold [CHANNELS];
  logic [CNT_W-1:0] count;
  // engine fetch that lost to a core fetch or a pending engine fetch, served next cycle
  logic eng_pend;
  logic [CH_W-1:0] eng_pend_ch;
  logic [PTR_W-1:0] eng_pend_ptr;

  // page bit comes from the channel number, no bounds check
  function automatic logic [ADDR_W-1:0] page_addr(
    input logic [CH_W-1:0] ch,
    input logic [PTR_W-1:0] ptr
  );
    page_addr = {ch[PAGE_BIT], ptr};
  endfunction : page_addr

  // pointer advance wraps inside the page on purpose
  function automatic logic [PTR_W-1:0] bump(
    input logic [PTR_W-1:0] ptr
  );
    bump = ptr + PTR_STEP;
  endfunction : bump

  // one decode of a core strobe against a register select
  function automatic logic core_hit(
    input logic strobe,
    input logic [1:0] sel_now,
    input logic [1:0] sel_want
  );
    core_hit = strobe && (sel_now == sel_want);
  endfunction : core_hit

  // ****************************************************************
  // engine offset addressing
  // ****************************************************************
  logic [PTR_W-1:0] eng_rd_ptr;
  logic [PTR_W-1:0] eng_wr_ptr;
  logic eng_store;
  logic [CNT_W-1:0] eff_count;

  always_comb
  begin
    eff_count = engine_i.restart ? CNT_ZERO : count;
    // next byte after the one being taken, offset from base
    eng_rd_ptr = bump(rptr[engine_i.ch] + eff_count[PTR_W-1:0]);
    eng_wr_ptr = wptr[engine_i.ch] + eff_count[PTR_W-1:0];
    eng_store = engine_i.out_put && (eff_count < engine_i.limit);
  end

  // ****************************************************************
  // fetch arbitration
  // ****************************************************************
  logic core_fetch;
  logic [PTR_W-1:0] core_fetch_ptr;

  always_comb
  begin
    core_fetch = 1'b0;
    core_fetch_ptr = rptr[core_i.ch];
    if (core_hit(core_i.wr, core_i.sel, SEL_RPTR))
    begin
      core_fetch = 1'b1;
      core_fetch_ptr = core_i.wdata;
    end
    else if (core_hit(core_i.rd, core_i.sel, SEL_DATA))
    begin
      core_fetch = 1'b1;
      core_fetch_ptr = bump(rptr[core_i.ch]);
    end
  end

  // ****************************************************************
  // memory writes: core and engine on separate ports
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (core_hit(core_i.wr, core_i.sel, SEL_DATA))
      mem[page_addr(core_i.ch, wptr[core_i.ch])] <= core_i.wdata;
    if (eng_store)
      mem[page_addr(engine_i.ch, eng_wr_ptr)] <= engine_i.wdata;
  end

  // ****************************************************************
  // channel pointers
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        wptr[i] <= PTR_RESET;
        rptr[i] <= PTR_RESET;
      end
    end
    else
    begin
      // only the core writes pointers; the engine never moves them, so no clash here
      if (core_hit(core_i.wr, core_i.sel, SEL_WPTR))
        wptr[core_i.ch] <= core_i.wdata;
      if (core_hit(core_i.wr, core_i.sel, SEL_DATA))
        wptr[core_i.ch] <= bump(wptr[core_i.ch]);
      if (core_fetch)
        rptr[core_i.ch] <= core_fetch_ptr;
    end
  end

  // ****************************************************************
  // data holding registers, prefetch and deferral
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < CHANNELS; i++)
        hold[i] <= BYTE_ZERO;
      eng_pend <= 1'b0;
      eng_pend_ch <= '0;
      eng_pend_ptr <= PTR_RESET;
    end
    else
    begin
      eng_pend <= 1'b0;
      // a deferred engine fetch goes first; a core fetch to the same channel overrides it
      if (eng_pend)
        hold[eng_pend_ch] <= mem[page_addr(eng_pend_ch, eng_pend_ptr)];
      if (core_fetch)
        hold[core_i.ch] <= mem[page_addr(core_i.ch, core_fetch_ptr)];
      if (engine_i.in_take)
      begin
        if (core_fetch || eng_pend)
        begin
          eng_pend <= 1'b1;
          eng_pend_ch <= engine_i.ch;
          eng_pend_ptr <= eng_rd_ptr;
        end
        else
          hold[engine_i.ch] <= mem[page_addr(engine_i.ch, eng_rd_ptr)];
      end
    end
  end

  // ****************************************************************
  // read data and engine byte counter
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      core_rdata_o <= BYTE_ZERO;
    else if (core_i.rd)
    begin
      if (core_i.sel == SEL_WPTR)
        core_rdata_o <= wptr[core_i.ch];
      else if (core_i.sel == SEL_RPTR)
        core_rdata_o <= rptr[core_i.ch];
      else
        core_rdata_o <= hold[core_i.ch];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      engine_rdata_o <= BYTE_ZERO;
    else if (engine_i.in_take)
      engine_rdata_o <= hold[engine_i.ch];
  end

  // counter keeps counting dropped bytes so the reported size is true
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      count <= CNT_ZERO;
    else if (engine_i.in_take || engine_i.out_put)
      count <= eff_count + CNT_STEP;
    else if (engine_i.restart)
      count <= CNT_ZERO;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      engine_count_o <= CNT_ZERO;
    else
      engine_count_o <= count;
  end

endmodule : packet_memory_arbiter

//--- pma_props.sv
// checker: port assertions for the packet memory arbiter
`timescale 1ns/1ps
module pma_props
  import pma_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire core_req_t core_i,
  input wire logic [7:0] core_rdata_o,
  input wire engine_req_t engine_i,
  input wire logic [7:0] engine_rdata_o,
  input wire logic [CNT_W-1:0] engine_count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ****
  // core steps
  // ****
  sequence s_store;
    core_i.wr && core_i.sel == SEL_WPTR ##1
    (core_i.wr && core_i.sel == SEL_DATA && $stable(core_i.ch));
  endsequence
  sequence s_load;
    core_i.wr && core_i.sel == SEL_RPTR && $stable(core_i.ch) &&
    core_i.wdata == $past(core_i.wdata, 2);
  endsequence
  sequence s_get;
    core_i.rd && core_i.sel == SEL_DATA && $stable(core_i.ch);
  endsequence
  a_loop_back:
    assert property (s_store ##1 s_load ##1 s_get |=>
      core_rdata_o == $past(core_i.wdata, 3)) else $error("core loop");
  a_in_preload:
    assert property (s_store ##1 s_load ##1 (engine_i.in_take &&
      engine_i.restart && engine_i.ch == $past(core_i.ch)) |=>
      engine_rdata_o == $past(core_i.wdata, 3)) else $error("in first");
  a_out_loop:
    assert property (core_i.wr && core_i.sel == SEL_WPTR ##1
      (engine_i.out_put && engine_i.restart && !core_i.wr &&
      !core_i.rd && engine_i.limit != CNT_ZERO &&
      engine_i.ch == $past(core_i.ch)) ##1 s_load ##1 s_get |=>
      core_rdata_o == $past(engine_i.wdata, 3)) else $error("out byte");
  a_restart_zero:
    assert property (engine_i.restart && !engine_i.out_put &&
      !engine_i.in_take |-> ##2 engine_count_o == CNT_ZERO)
      else $error("count restart");
  a_count_step:
    assert property ((engine_i.out_put || engine_i.in_take) &&
      !engine_i.restart |-> ##2 engine_count_o ==
      $past(engine_count_o) + CNT_STEP) else $error("count step");
  a_count_hold:
    assert property (!(engine_i.out_put || engine_i.in_take ||
      engine_i.restart) |-> ##2 $stable(engine_count_o))
      else $error("count hold");
  a_core_hold:
    assert property (!core_i.rd |=> $stable(core_rdata_o))
      else $error("core data moved");
  a_engine_hold:
    assert property (!engine_i.in_take |=> $stable(engine_rdata_o))
      else $error("engine data moved");
endmodule : pma_props
bind packet_memory_arbiter pma_props u_pma_props (.clk_i, .rstn_i,
  .core_i, .core_rdata_o, .engine_i, .engine_rdata_o, .engine_count_o);

//--- engine_model.sv
// model: serial engine side of the packet memory arbiter
`timescale 1ns/1ps
module engine_model
  import pma_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output engine_req_t req_o
);
  initial req_o = '0;
  // k is {take, put, restart}; one request per call, no release
  task automatic op(logic [2:0] k, logic [3:0] c, logic [7:0] v,
    logic [9:0] lim, output logic [7:0] got);
    req_o = {k, c, v, lim};
    @(posedge clk_i);
    #1 got = rdata_i;
  endtask : op
  // released data shows inverted bits, never the last byte
  task automatic rest();
    req_o = {3'h0, req_o.ch, ~req_o.wdata, req_o.limit};
  endtask : rest
endmodule : engine_model

//--- usb_sram_channel_arbiter_test.sv
// testbench: core and engine traffic through the packet memory arbiter
`timescale 1ns/1ps
module usb_sram_channel_arbiter_test;
  import pma_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  core_req_t core = '0;
  engine_req_t eng;
  logic [7:0] crd, erd, got, a, d[5];
  logic [CNT_W-1:0] cnt;
  logic [3:0] ch;
  int n;
  int bad_count = 0;
  int checks_done = 0;
  always #4 clk_i = ~clk_i;
  packet_memory_arbiter u_packet_memory_arbiter (.clk_i, .rstn_i,
    .core_i(core), .core_rdata_o(crd), .engine_i(eng),
    .engine_rdata_o(erd), .engine_count_o(cnt));
  engine_model u_engine_model (.clk_i, .rdata_i(erd), .req_o(eng));
  // ****
  // helpers
  // ****
  function automatic logic [7:0] kept(int j, int lim, logic [7:0] v,
    logic [7:0] old);
    return (j < lim) ? v : old;
  endfunction : kept
  // pointers wrap in eight bits, so the sum is cut to a byte
  function automatic logic [7:0] ptr_after(logic [7:0] base, int steps);
    return base + 8'(steps);
  endfunction : ptr_after
  task automatic chk_byte(string w, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : chk_byte
  task automatic chk_count(string w, logic [CNT_W-1:0] e,
    logic [CNT_W-1:0] s);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s count expected %h seen %h", w, e, s);
    end
  endtask : chk_count
  task automatic cq(logic [1:0] k, logic [3:0] c, logic [1:0] s,
    logic [7:0] v);
    core = {k, c, s, v};
    @(posedge clk_i);
    #1;
  endtask : cq
  task automatic fill(logic [3:0] c, int m);
    cq(2'b10, c, SEL_WPTR, a);
    for (int j = 0; j < m; j++)
    begin
      d[j] = 8'($urandom);
      cq(2'b10, c, SEL_DATA, d[j]);
    end
  endtask : fill
  task automatic rb(logic [3:0] c, int m);
    cq(2'b10, c, SEL_RPTR, a);
    for (int j = 0; j < m; j++)
    begin
      cq(2'b01, c, SEL_DATA, a);
      chk_byte("core data", d[j], crd);
    end
  endtask : rb
  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial
  begin
    void'($urandom(32'he5d7f753));
    repeat (4) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    // page 1 loops; pass 0 is one byte, pass 1 starts at fe so two or more bytes wrap the pointer
    for (int i = 0; i < 6; i++)
    begin
      ch = 4'h8 + 4'($urandom_range(7));
      a = (i == 1) ? 8'hfe : 8'($urandom);
      n = (i == 0) ? 1 : $urandom_range(4, 1);
      fill(ch, n);
      rb(ch, n);
      cq(2'b01, ch, SEL_WPTR, a);
      chk_byte("write pointer", ptr_after(a, n), crd);
    end
    // one pointer value in each page must keep two different bytes
    a = 8'($urandom);
    fill(4'h5, 1);
    d[4] = d[0];
    fill(4'hd, 1);
    rb(4'hd, 1);
    d[0] = d[4];
    rb(4'h5, 1);
    for (int i = 0; i < 2; i++)
    begin
      n = i * 3 + 1;
      a = 8'($urandom);
      fill(4'h2, n);
      rb(4'h2, 0);
      core.wr = 1'b0;
      for (int j = 0; j < n; j++)
      begin
        u_engine_model.op({2'b10, j == 0}, 4'h2, a, 10'h000, got);
        chk_byte("in byte", d[j], got);
        u_engine_model.rest();
        @(posedge clk_i) #1;
      end
      chk_count("in count", 10'(n), cnt);
    end
    a = 8'($urandom);
    cq(2'b10, 4'h1, SEL_WPTR, a);
    core.wr = 1'b0;
    u_engine_model.op(3'b011, 4'h1, a, 10'h040, got);
    u_engine_model.rest();
    d[0] = a;
    rb(4'h1, 1);
    fill(4'h0, 4);
    cq(2'b10, 4'h1, SEL_WPTR, a);
    core.wr = 1'b0;
    for (int j = 0; j < 5; j++)
    begin
      u_engine_model.op({2'b01, j == 0}, 4'h1, ~d[j], 10'h003, got);
      d[j] = kept(j, 3, ~d[j], d[j]);
    end
    u_engine_model.rest();
    @(posedge clk_i) #1;
    chk_count("out count", 10'h005, cnt);
    rb(4'h0, 4);
    core.rd = 1'b0;
    u_engine_model.op(3'b001, 4'h1, a, 10'h003, got);
    for (int j = 0; j < 2; j++)
    begin
      u_engine_model.op(3'b010, 4'h1, d[j] + 8'h01, 10'h003, got);
      d[j] = kept(j, 3, d[j] + 8'h01, d[j]);
    end
    u_engine_model.rest();
    @(posedge clk_i) #1;
    chk_count("resend count", 10'h002, cnt);
    rb(4'h0, 4);
    print_verdict();
  end
endmodule : usb_sram_channel_arbiter_test
